// File: hw/wfd_top.sv
// wake frame and wake pattern packet detector with apb registers
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module wfd_top
    import wfd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_data,
    input  wire logic        light_sleep_state,
    output logic             rx_suppress,
    output logic             host_irq,
    output logic             power_event_output
);
    ////////////////////////////////////////////////////////////////////////
    // registers and nets
    logic [31:0]          filt_r [WFD_FWORDS];
    logic [2:0]           fptr_r;
    logic                 pkt_en_r;
    logic                 frm_en_r;
    logic                 pkt_rx_r;
    logic                 frm_rx_r;
    logic                 pme_sel_r;
    logic [47:0]          mac_r;
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic                 suppress_r;
    logic                 irq_r;
    logic                 pme_r;
    logic [WFD_IDX_W-1:0] idx_r;
    logic [WFD_IDX_W-1:0] cur_idx;
    logic                 da_own_r;
    logic                 da_bcast_r;
    logic                 da_mcast_r;
    logic                 eof_d_r;
    logic                 pkt_on;
    logic                 frm_on;
    logic                 acc;
    logic                 wr;
    logic                 mapped;
    logic                 pkt_found;
    logic [3:0]           filt_match;
    logic [3:0]           filt_ok;
    logic                 pkt_hit;
    logic                 frm_hit;
    logic                 clr_pkt;
    logic                 clr_frm;
    logic [7:0]           own_byte;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: setup then one access cycle
    assign acc    = psel && penable && pready_r;
    assign wr     = acc && pwrite;
    assign mapped = (paddr == WFD_A_FILT) || (paddr == WFD_A_CTRL)
                    || (paddr == WFD_A_MACL) || (paddr == WFD_A_MACH);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable) begin
            if (paddr == WFD_A_FILT) begin
                prdata_r <= filt_r[fptr_r];
            end else if (paddr == WFD_A_CTRL) begin
                prdata_r <= '0;
                prdata_r[WFD_B_PKT_EN]  <= pkt_en_r;
                prdata_r[WFD_B_FRM_EN]  <= frm_en_r;
                prdata_r[WFD_B_PKT_RX]  <= pkt_rx_r;
                prdata_r[WFD_B_FRM_RX]  <= frm_rx_r;
                prdata_r[WFD_B_PME_SEL] <= pme_sel_r;
            end else if (paddr == WFD_A_MACL) begin
                prdata_r <= mac_r[31:0];
            end else if (paddr == WFD_A_MACH) begin
                prdata_r <= {16'h0000, mac_r[47:32]};
            end else begin
                prdata_r <= '0;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////
    // filter table: eight successive writes through one port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fptr_r <= '0;
            for (int i = 0; i < WFD_FWORDS; i++) begin
                filt_r[i] <= '0;
            end
        end else if (wr && paddr == WFD_A_FILT) begin
            filt_r[fptr_r] <= pwdata;
            fptr_r         <= fptr_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control, station address and sticky status
    assign clr_pkt = wr && paddr == WFD_A_CTRL && pwdata[WFD_B_PKT_RX];
    assign clr_frm = wr && paddr == WFD_A_CTRL && pwdata[WFD_B_FRM_RX];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_en_r  <= 1'b0;
            frm_en_r  <= 1'b0;
            pme_sel_r <= 1'b0;
            mac_r     <= '0;
        end else if (wr) begin
            if (paddr == WFD_A_CTRL) begin
                pkt_en_r  <= pwdata[WFD_B_PKT_EN];
                frm_en_r  <= pwdata[WFD_B_FRM_EN];
                pme_sel_r <= pwdata[WFD_B_PME_SEL];
            end else if (paddr == WFD_A_MACL) begin
                mac_r[31:0] <= pwdata;
            end else if (paddr == WFD_A_MACH) begin
                mac_r[47:32] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_rx_r <= 1'b0;
            frm_rx_r <= 1'b0;
        end else begin
            if (pkt_hit) begin
                pkt_rx_r <= 1'b1;
            end else if (clr_pkt) begin
                pkt_rx_r <= 1'b0;
            end
            if (frm_hit) begin
                frm_rx_r <= 1'b1;
            end else if (clr_frm) begin
                frm_rx_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state and mode
    assign pkt_on = pkt_en_r || light_sleep_state;
    assign frm_on = frm_en_r || light_sleep_state;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suppress_r <= 1'b0;
            irq_r      <= 1'b0;
            pme_r      <= 1'b0;
        end else begin
            suppress_r <= pkt_on || frm_on;
            irq_r      <= (pkt_rx_r || frm_rx_r) && !pme_sel_r;
            pme_r      <= (pkt_rx_r || frm_rx_r) && pme_sel_r;
        end
    end

    assign rx_suppress        = suppress_r;
    assign host_irq           = irq_r;
    assign power_event_output = pme_r;

    ////////////////////////////////////////////////////////////////////////
    // frame byte index and destination classification
    assign cur_idx  = rx_sof ? '0 : idx_r;
    assign own_byte = mac_r[8*cur_idx[2:0] +: 8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= '0;
        end else if (rx_valid) begin
            idx_r <= (&cur_idx) ? cur_idx : cur_idx + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            da_own_r   <= 1'b0;
            da_bcast_r <= 1'b0;
            da_mcast_r <= 1'b0;
        end else if (rx_valid && rx_sof) begin
            da_own_r   <= rx_data == own_byte;
            da_bcast_r <= rx_data == WFD_SYNC_BYTE;
            da_mcast_r <= rx_data[0];
        end else if (rx_valid && cur_idx <= WFD_DA_LAST) begin
            da_own_r   <= da_own_r && rx_data == own_byte;
            da_bcast_r <= da_bcast_r && rx_data == WFD_SYNC_BYTE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eof_d_r <= 1'b0;
        end else begin
            eof_d_r <= rx_valid && rx_eof;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // detectors
    wfd_pattern u_pattern (
        .pclk     (pclk),
        .presetn  (presetn),
        .byte_vld (rx_valid),
        .byte_dat (rx_data),
        .byte_idx (cur_idx),
        .station  (mac_r),
        .found    (pkt_found)
    );

    for (genvar g = 0; g < WFD_NFILT; g++) begin : g_filt
        wfd_filter u_filter (
            .pclk     (pclk),
            .presetn  (presetn),
            .byte_vld (rx_valid),
            .byte_dat (rx_data),
            .byte_idx (cur_idx),
            .mask     (filt_r[g][30:0]),
            .offset   (filt_r[WFD_W_OFS][8*g +: 8]),
            .crc_exp  (filt_r[WFD_W_CRC01 + 3'(g/2)][16*(g%2) +: 16]),
            .match    (filt_match[g])
        );
        assign filt_ok[g] = filt_r[WFD_W_CMD][8*g + WFD_CMD_EN]
            && filt_match[g]
            && (filt_r[WFD_W_CMD][8*g + WFD_CMD_MCAST]
                ? da_mcast_r : da_own_r);
    end

    assign pkt_hit = eof_d_r && pkt_on && pkt_found
                     && (da_own_r || da_bcast_r || da_mcast_r);
    assign frm_hit = eof_d_r && frm_on && (|filt_ok);

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_status_pkt_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        pkt_hit |=> pkt_rx_r) else $error("pattern status not set");

    a_status_frm_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm_hit |=> frm_rx_r) else $error("frame status not set");

    a_pkt_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        pkt_rx_r && !clr_pkt |=> pkt_rx_r)
        else $error("pattern status lost");

    a_frm_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm_rx_r && !clr_frm |=> frm_rx_r)
        else $error("frame status lost");

    a_pkt_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        clr_pkt && !pkt_hit |=> !pkt_rx_r)
        else $error("pattern status not cleared");

    a_irq_route_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pkt_rx_r && !pme_sel_r) ##1 (pkt_rx_r && !pme_sel_r)
        |-> host_irq && !power_event_output)
        else $error("irq routing wrong");

    a_pme_route_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past((pkt_rx_r || frm_rx_r) && pme_sel_r)
        |-> power_event_output && !host_irq)
        else $error("power event routing wrong");

    a_sleep_forces_on: assert property (
        @(posedge pclk) disable iff (!presetn)
        light_sleep_state |=> rx_suppress)
        else $error("light sleep did not enable detection");

    a_mode_leaves_rx: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!pkt_en_r && !frm_en_r && !light_sleep_state) |=> !rx_suppress)
        else $error("reception not restored");

    a_hit_needs_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pkt_rx_r) |-> $past(pkt_en_r || light_sleep_state))
        else $error("pattern hit while off");

    a_frm_needs_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(frm_rx_r) |-> $past(frm_en_r || light_sleep_state))
        else $error("frame hit while off");

    a_dest_qualify: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pkt_rx_r) |-> $past(da_own_r || da_bcast_r || da_mcast_r))
        else $error("pattern hit on foreign frame");

    a_filter_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == WFD_A_FILT) |=> fptr_r == $past(fptr_r) + 3'h1)
        else $error("filter pointer not advanced");

    a_apb_one_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready) else $error("apb answer late");

    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("apb ready held");

    a_unmapped_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");
endmodule

// File: hw/wfd_pkg.sv
// package: register map, field positions and constants of the wake detector
package wfd_pkg;
    localparam logic [7:0]  WFD_A_FILT     = 8'h00;
    localparam logic [7:0]  WFD_A_CTRL     = 8'h04;
    localparam logic [7:0]  WFD_A_MACL     = 8'h08;
    localparam logic [7:0]  WFD_A_MACH     = 8'h0C;
    localparam int          WFD_B_PKT_EN   = 1;
    localparam int          WFD_B_FRM_EN   = 2;
    localparam int          WFD_B_PKT_RX   = 5;
    localparam int          WFD_B_FRM_RX   = 6;
    localparam int          WFD_B_PME_SEL  = 8;
    localparam int          WFD_NFILT      = 4;
    localparam int          WFD_FWORDS     = 8;
    localparam logic [2:0]  WFD_W_CMD      = 3'h4;
    localparam logic [2:0]  WFD_W_OFS      = 3'h5;
    localparam logic [2:0]  WFD_W_CRC01    = 3'h6;
    localparam logic [2:0]  WFD_W_CRC23    = 3'h7;
    localparam int          WFD_CMD_EN     = 0;
    localparam int          WFD_CMD_MCAST  = 3;
    localparam int          WFD_MASK_BITS  = 31;
    localparam int          WFD_IDX_W      = 11;
    localparam logic [10:0] WFD_HDR_BYTES  = 11'h00C;
    localparam logic [10:0] WFD_DA_LAST    = 11'h005;
    localparam logic [2:0]  WFD_SYNC_LAST  = 3'h5;
    localparam logic [2:0]  WFD_ADDR_LAST  = 3'h5;
    localparam logic [3:0]  WFD_COPY_LAST  = 4'hF;
    localparam logic [7:0]  WFD_SYNC_BYTE  = 8'hFF;
    localparam logic [15:0] WFD_CRC_POLY   = 16'h8005;
    localparam logic [15:0] WFD_CRC_INIT   = 16'hFFFF;
    typedef enum logic [0:0] {WFD_HUNT, WFD_COPY} wfd_state_t;
endpackage

// File: hw/wfd_filter.sv
// one wake filter: masked crc-16 over the frame bytes
`timescale 1ns/1ps
module wfd_filter
    import wfd_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 byte_vld,
    input  wire logic [7:0]           byte_dat,
    input  wire logic [WFD_IDX_W-1:0] byte_idx,
    input  wire logic [30:0]          mask,
    input  wire logic [7:0]           offset,
    input  wire logic [15:0]          crc_exp,
    output logic                      match
);
    logic [15:0]          crc_r;
    logic [WFD_IDX_W-1:0] rel;
    logic                 in_win;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            if (r[15] ^ d[k]) begin
                r = {r[14:0], 1'b0} ^ WFD_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    assign rel    = byte_idx - {3'h0, offset};
    assign in_win = (byte_idx >= {3'h0, offset})
                    && (rel < WFD_IDX_W'(WFD_MASK_BITS));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_r <= WFD_CRC_INIT;
        end else if (byte_vld && byte_idx == '0) begin
            crc_r <= WFD_CRC_INIT;
        end else if (byte_vld && in_win && mask[rel[4:0]]) begin
            crc_r <= crc_step(crc_r, byte_dat);
        end
    end

    assign match = (crc_r == crc_exp);
endmodule

// File: hw/wfd_pattern.sv
// wake pattern packet search: sync run then sixteen address copies
`timescale 1ns/1ps
module wfd_pattern
    import wfd_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 byte_vld,
    input  wire logic [7:0]           byte_dat,
    input  wire logic [WFD_IDX_W-1:0] byte_idx,
    input  wire logic [47:0]          station,
    output logic                      found
);
    wfd_state_t state_r;
    logic [2:0] ff_r;
    logic [2:0] pos_r;
    logic [3:0] copies_r;
    logic       found_r;
    logic       is_ff;

    assign is_ff = (byte_dat == WFD_SYNC_BYTE);
    assign found = found_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= WFD_HUNT;
            ff_r     <= '0;
            pos_r    <= '0;
            copies_r <= '0;
            found_r  <= 1'b0;
        end else if (byte_vld && byte_idx < WFD_HDR_BYTES) begin
            state_r  <= WFD_HUNT;
            ff_r     <= '0;
            pos_r    <= '0;
            copies_r <= '0;
            if (byte_idx == '0) begin
                found_r <= 1'b0;
            end
        end else if (byte_vld) begin
            case (state_r)
                WFD_HUNT: begin
                    if (is_ff) begin
                        ff_r <= (ff_r == WFD_SYNC_LAST) ? ff_r : ff_r + 3'h1;
                        if (ff_r == WFD_SYNC_LAST) begin
                            state_r  <= WFD_COPY;
                            pos_r    <= '0;
                            copies_r <= '0;
                        end
                    end else begin
                        ff_r <= '0;
                    end
                end
                WFD_COPY: begin
                    if (pos_r == '0 && copies_r == '0 && is_ff) begin
                        state_r <= WFD_COPY;
                    end else if (byte_dat == station[8*pos_r +: 8]) begin
                        if (pos_r != WFD_ADDR_LAST) begin
                            pos_r <= pos_r + 3'h1;
                        end else if (copies_r == WFD_COPY_LAST) begin
                            found_r <= 1'b1;
                            state_r <= WFD_HUNT;
                            ff_r    <= '0;
                        end else begin
                            pos_r    <= '0;
                            copies_r <= copies_r + 4'h1;
                        end
                    end else begin
                        state_r <= WFD_HUNT;
                        ff_r    <= is_ff ? 3'h1 : 3'h0;
                    end
                end
                default: state_r <= WFD_HUNT;
            endcase
        end
    end

    a_copy_needs_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_r == WFD_COPY)
        |-> $past(is_ff) && $past(ff_r) == WFD_SYNC_LAST)
        else $error("copy phase without sync run");
endmodule

// File: sim/wfd_rx_model.sv
// partner model: mac receive byte stream feeding the detector
`timescale 1ns/1ps
module wfd_rx_model (
    input  wire logic       pclk,
    output logic            rx_valid,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic [7:0]      rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_sof   = 1'b0;
        rx_eof   = 1'b0;
        rx_data  = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // one byte per edge, gap idle cycles between bytes
    task automatic send(input logic [7:0] f[$], input int gap);
        for (int i = 0; i < f.size(); i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == f.size() - 1);
            rx_data  <= f[i];
            repeat (gap) begin
                @(posedge pclk);
                rx_valid <= 1'b0;
                rx_sof   <= 1'b0;
                rx_eof   <= 1'b0;
                rx_data  <= ~f[i];
            end
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_sof   <= 1'b0;
        rx_eof   <= 1'b0;
        rx_data  <= ~rx_data;
    endtask
endmodule

// File: sim/wfd_top_test.sv
// testbench: registers, pattern packet and wake filter scenarios
`timescale 1ns/1ps
module wfd_top_test
    import wfd_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, light_sleep_state;
    logic [7:0]  paddr, rx_data;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, rx_valid, rx_sof, rx_eof, er;
    logic        rx_suppress, host_irq, power_event_output;
    logic [7:0]  fr[$];
    int          fails, num_checks;
    localparam logic [47:0] STN = 48'h5544_3322_1100;
    localparam logic [47:0] MCA = 48'h0605_0403_0201;
    localparam logic [47:0] OTH = 48'h5544_3322_1102;

    wfd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_data(rx_data), .light_sleep_state(light_sleep_state),
        .rx_suppress(rx_suppress), .host_irq(host_irq),
        .power_event_output(power_event_output));
    wfd_rx_model mac (.pclk(pclk), .rx_valid(rx_valid), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_data(rx_data));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask

    task automatic hdr(input logic [47:0] da);
        fr.delete();
        for (int k = 0; k < 6; k++) fr.push_back(da[8*k +: 8]);
        for (int k = 0; k < 6; k++) fr.push_back(8'h02 + 8'(k));
    endtask

    // optional sync run, then n station copies
    task automatic cp(input logic s, input int n);
        if (s) repeat (6) fr.push_back(8'hFF);
        repeat (n) for (int k = 0; k < 6; k++) fr.push_back(STN[8*k +: 8]);
    endtask

    task automatic go(input int gap);
        repeat (4) fr.push_back(8'h5A);
        mac.send(fr, gap);
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [15:0] crc16(input logic [31:0] w);
        logic [15:0] c;
        c = WFD_CRC_INIT;
        for (int i = 0; i < 4; i++) begin
            c = c ^ {w[31-8*i -: 8], 8'h00};
            for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ WFD_CRC_POLY
                                                  : c << 1;
        end
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_regs();
        rdc("ctrl_rst", WFD_A_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("slverr", er, 32'h0000_0001);
        chk("unm_rd", rd, 32'h0000_0000);
        wr(WFD_A_CTRL, 32'h0000_0102);
        rdc("ctrl_rw", WFD_A_CTRL, 32'h0000_0102);
        chk("slverr0", er, 32'h0000_0000);
        chk("sup_pkt", rx_suppress, 32'h0000_0001);
        wr(WFD_A_CTRL, 32'h0000_0004);
        rdc("ctrl_frm", WFD_A_CTRL, 32'h0000_0004);
        chk("sup_frm", rx_suppress, 32'h0000_0001);
        wr(WFD_A_CTRL, 32'h0000_0000);
        rdc("ctrl_off", WFD_A_CTRL, 32'h0000_0000);
        chk("sup_off", rx_suppress, 32'h0000_0000);
        wr(WFD_A_MACL, 32'h3322_1100);
        wr(WFD_A_MACH, 32'h0000_5544);
        rdc("macl", WFD_A_MACL, 32'h3322_1100);
        rdc("mach", WFD_A_MACH, 32'h0000_5544);
    endtask

    task automatic s_pkt();
        logic [47:0] da[3];
        logic [31:0] ex[3];
        da = '{OTH, 48'hFFFF_FFFF_FFFF, MCA};
        ex = '{32'h0000_0002, 32'h0000_0022, 32'h0000_0022};
        wr(WFD_A_CTRL, 32'h0000_0002);
        hdr(STN);
        cp(1'b1, 15);
        fr.push_back(8'h00);
        cp(1'b0, 16);
        go(0);
        rdc("run15", WFD_A_CTRL, 32'h0000_0002);
        hdr(STN);
        fr.push_back(8'h00);
        cp(1'b1, 3);
        fr.push_back(8'h00);
        cp(1'b1, 16);
        go(1);
        rdc("pkt_st", WFD_A_CTRL, 32'h0000_0022);
        chk("irq", host_irq, 32'h0000_0001);
        chk("pme_idle", power_event_output, 32'h0000_0000);
        repeat (20) @(posedge pclk);
        chk("irq_hold", host_irq, 32'h0000_0001);
        wr(WFD_A_CTRL, 32'h0000_0022);
        rdc("pkt_clr", WFD_A_CTRL, 32'h0000_0002);
        chk("irq_clr", host_irq, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            hdr(da[i]);
            cp(1'b1, 16);
            go(0);
            rdc("pkt_da", WFD_A_CTRL, ex[i]);
            wr(WFD_A_CTRL, 32'h0000_0022);
        end
    endtask

    task automatic s_sleep();
        wr(WFD_A_CTRL, 32'h0000_0100);
        hdr(STN);
        cp(1'b1, 16);
        go(0);
        rdc("awake_off", WFD_A_CTRL, 32'h0000_0100);
        light_sleep_state <= 1'b1;
        hdr(STN);
        cp(1'b1, 16);
        go(0);
        rdc("sleep_pkt", WFD_A_CTRL, 32'h0000_0120);
        chk("sleep_sup", rx_suppress, 32'h0000_0001);
        chk("pme", power_event_output, 32'h0000_0001);
        chk("irq_idle", host_irq, 32'h0000_0000);
        wr(WFD_A_CTRL, 32'h0000_0120);
        light_sleep_state <= 1'b0;
        rdc("sleep_clr", WFD_A_CTRL, 32'h0000_0100);
        chk("pme_clr", power_event_output, 32'h0000_0000);
    endtask

    task automatic s_filt();
        logic [15:0] c;
        logic [31:0] w[8];
        logic [31:0] ex[5];
        c = crc16(32'hA1B2_C3D4);
        // frames on, frames on, bad crc, frames off, light sleep
        ex = '{32'h0000_0044, 32'h0000_0044, 32'h0000_0004, 32'h0000_0000,
               32'h0000_0040};
        // offsets of filters 0 and 1 kept at twelve, past both address fields
        w = '{32'h0000_000F, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000,
              32'h0000_0901, 32'h0000_0C0C, {c, c}, 32'h0000_0000};
        for (int i = 0; i < 8; i++) wr(WFD_A_FILT, w[i]);
        rdc("filt_wrap", WFD_A_FILT, 32'h0000_000F);
        wr(WFD_A_CTRL, 32'h0000_0004);
        for (int j = 0; j < 5; j++) begin
            light_sleep_state <= (j == 4);
            hdr(j == 1 ? MCA : STN);
            fr.push_back(8'hA1);
            fr.push_back(8'hB2);
            fr.push_back(8'hC3);
            fr.push_back(j == 2 ? 8'hD5 : 8'hD4);
            repeat (8) fr.push_back(8'h3C);
            go(0);
            rdc("filt", WFD_A_CTRL, ex[j]);
            chk("frm_sup", rx_suppress, j == 3 ? 32'h0 : 32'h1);
            wr(WFD_A_CTRL, j < 2 ? 32'h0000_0044 : 32'h0000_0040);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fails             = 0;
        num_checks        = 0;
        presetn           = 1'b0;
        psel              = 1'b0;
        penable           = 1'b0;
        light_sleep_state = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_pkt();
        s_sleep();
        s_filt();
        close_out();
    end
endmodule
